// ---- verilog/pirs_regs.v ----
// apb register bank: adc irq enable, adc done flag, power-on reset status
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "pirs_defs.vh"
module pirs_regs
(
    input  wire        clk,
    input  wire        rst_n,
    input  wire        por_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        adc_conv_done,
    input  wire [7:0]  main_irq_control_reg,
    output wire        adc_irq_req,
    output wire        adc_irq_enable,
    output wire        adc_done_flag,
    output wire        poweron_reset_flag
);
    reg  adc_irq_enable_q;
    reg  por_flag_q;
    wire access;
    wire wr;
    wire hit_flag;
    wire hit_enable;
    wire hit_power;
    wire hit_any;
    wire lane0;
    reg  [7:0] next_rdata;

    // zero wait states: every access completes in its first access cycle
    assign access     = psel & penable;
    assign pready     = 1'b1;
    assign hit_flag   = (paddr == `PIRS_ADDR_FLAG);
    assign hit_enable = (paddr == `PIRS_ADDR_ENABLE);
    assign hit_power  = (paddr == `PIRS_ADDR_POWER);
    assign hit_any    = hit_flag | hit_enable | hit_power;
    assign pslverr    = access & ~hit_any;
    assign wr         = access & pwrite;
    // all bits sit in the low byte lane
    assign lane0      = pstrb[0];

    // enable register; only bit 6 is storage
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            adc_irq_enable_q <= `PIRS_RST_ENABLE;
        else if (wr & hit_enable & lane0)
            adc_irq_enable_q <= pwdata[`PIRS_BIT_ADC];
    end

    // flag: sticky, set wins, cleared only by a software write or by rst_n
    pirs_sticky_bit u_adc_flag
    (
        .clk     (clk),
        .rst_n   (rst_n),
        .set_evt (adc_conv_done),
        .wr_en   (wr & hit_flag & lane0),
        .wr_val  (pwdata[`PIRS_BIT_ADC]),
        .q       (adc_done_flag)
    );

    // por flag lives on the power-on reset only; rst_n (pin or watchdog) leaves it alone
    always @(posedge clk or negedge por_n)
    begin
        if (!por_n)
            por_flag_q <= `PIRS_RST_POR;
        else if (rst_n & wr & hit_power & lane0)
            por_flag_q <= pwdata[`PIRS_BIT_POR];
    end

    assign adc_irq_enable     = adc_irq_enable_q;
    assign poweron_reset_flag = por_flag_q;

    assign adc_irq_req = adc_done_flag & adc_irq_enable_q
                       & main_irq_control_reg[`PIRS_BIT_PERIPH_EN]
                       & main_irq_control_reg[`PIRS_BIT_GLOBAL_EN];

    // read mux: unimplemented bits stay zero
    always @*
    begin
        next_rdata = 8'h00;
        if (hit_flag)
            next_rdata[`PIRS_BIT_ADC] = adc_done_flag;
        else if (hit_enable)
            next_rdata[`PIRS_BIT_ADC] = adc_irq_enable_q;
        else if (hit_power)
            next_rdata[`PIRS_BIT_POR] = por_flag_q;
    end

    // registered read data, loaded in the setup cycle so it is valid in access
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= {24'h00_0000, next_rdata};
    end
endmodule

// ---- common/pirs_defs.vh ----
// register offsets, field positions and reset values for the irq and reset status bank
`ifndef PIRS_DEFS_VH
`define PIRS_DEFS_VH

`define PIRS_OFF_FLAG      12'h00C
`define PIRS_OFF_ENABLE    12'h08C
`define PIRS_OFF_POWER     12'h08E

// 0x08e is not word aligned, so each offset is a word index: byte address is four times it
`define PIRS_ADDR_FLAG     12'h030
`define PIRS_ADDR_ENABLE   12'h230
`define PIRS_ADDR_POWER    12'h238

`define PIRS_BIT_ADC       6
`define PIRS_BIT_POR       1
`define PIRS_BIT_PERIPH_EN 6
`define PIRS_BIT_GLOBAL_EN 7

`define PIRS_RST_ENABLE    1'b0
`define PIRS_RST_FLAG      1'b0
`define PIRS_RST_POR       1'b0

`endif

// ---- verilog/pirs_sticky_bit.v ----
// one sticky flag bit: hardware set wins over software write
`timescale 1ns/1ps
module pirs_sticky_bit
(
    input  wire clk,
    input  wire rst_n,
    input  wire set_evt,
    input  wire wr_en,
    input  wire wr_val,
    output reg  q
);
    // set has priority, so an event in a clearing cycle is kept
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= 1'b0;
        else if (set_evt)
            q <= 1'b1;
        else if (wr_en)
            q <= wr_val;
    end
endmodule

// ---- bench/pirs_adc_model.sv ----
// converter stand-in: start strobe in, done out one cycle later and held as long as start was high
`timescale 1ns/1ps
module pirs_adc_model(input logic clk, start, output logic adc_conv_done = 1'b0);
    always @(posedge clk) adc_conv_done <= start;
endmodule

// ---- bench/pirs_regs_props.sv ----
// port checks for the irq and reset status bank
`timescale 1ns/1ps
module pirs_props(input logic clk, rst_n, por_n, adc_conv_done, adc_irq_req, adc_irq_enable, adc_done_flag,
    poweron_reset_flag, input logic [7:0] main_irq_control_reg);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_req_and: assert property (adc_irq_req == &{adc_done_flag, adc_irq_enable, main_irq_control_reg[7:6]})
        else $error("bad req");
    a_flag_set: assert property (adc_conv_done |=> adc_done_flag) else $error("bad set");
    a_pe_mask: assert property (!main_irq_control_reg[6] |-> !adc_irq_req) else $error("bad mask");
    a_glb_mask: assert property (!main_irq_control_reg[7] |-> !adc_irq_req) else $error("bad mask");
    a_en_mask: assert property (!adc_irq_enable |-> !adc_irq_req) else $error("bad mask");
    a_rst_en: assert property ($rose(rst_n) |-> !adc_irq_enable) else $error("bad init");
    a_por_clr: assert property ($rose(por_n) |-> !poweron_reset_flag) else $error("bad por");
    // pin reset must not disturb the power-on status, so only por_n masks this one
    a_por_keep: assert property (disable iff (!por_n) !rst_n |=> $stable(poweron_reset_flag)) else $error("por");
endmodule
bind pirs_regs pirs_props pirs_props_inst (.*);

// ---- bench/pirs_regs_tb.sv ----
// bench for the irq and reset status bank
`timescale 1ns/1ps
module pirs_regs_tb;
    logic clk = 0, rst_n = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, start = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [7:0] main_irq_control_reg = 0;
    logic [3:0] pstrb = 4'hF;
    wire pready, pslverr, adc_conv_done, adc_irq_req, adc_irq_enable, adc_done_flag, poweron_reset_flag;
    integer errors = 0, check_count = 0, n;
    always #20 clk = ~clk;
    pirs_adc_model pirs_adc_model_inst (.*);
    pirs_regs pirs_regs_inst (.*);
    task chk(input string nm, input logic [31:0] v, e);
        check_count++;
        if (v !== e) begin errors++; $display("unexpected %s exp %h seen %h", nm, e, v); end
    endtask
    task end_of_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task ap(input logic [11:0] a, input logic [31:0] d, e, input logic w);
        psel <= 1; paddr <= a; pwdata <= d; pwrite <= w;
        @(posedge clk) penable <= 1;
        n = 0;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (n == 20) begin errors++; end_of_test; end
        if (!w) chk("prdata", prdata, e);
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1; por_n <= 1;
        ap(12'h238, 0, 0, 0);
        ap(12'h030, 0, 0, 1);
        ap(12'h230, 32'hFFFF_FFFF, 0, 1);
        ap(12'h230, 0, 32'h40, 0);
        main_irq_control_reg <= 8'hC0; start <= 1;
        @(posedge clk) start <= 0;
        repeat (2) @(posedge clk);
        chk("adc_done_flag", adc_done_flag, 1);
        chk("adc_irq_req", adc_irq_req, 1);
        ap(12'h030, 0, 32'h40, 0);
        ap(12'h030, 0, 0, 1);
        ap(12'h030, 0, 0, 0);
        chk("adc_irq_req", adc_irq_req, 0);
        ap(12'h238, 32'hFFFF_FFFF, 0, 1);
        chk("poweron_reset_flag", poweron_reset_flag, 1);
        rst_n <= 0;
        @(posedge clk) rst_n <= 1;
        chk("adc_irq_enable", adc_irq_enable, 0);
        ap(12'h238, 0, 32'h2, 0);
        ap(12'h010, 0, 0, 0);
        end_of_test;
    end
endmodule
